// ### ir_pd_pkg.sv
// Constants, timing counts and state types for the pulse-distance infrared transmitter/receiver.
// Assumes one core clock whose period is given below; every count is derived from it.
package ir_pd_pkg;

    // ********************************************************************
    // Clock and protocol times
    // ********************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned BURST_NS = 562_500;
    localparam int unsigned LEAD_MARK_NS = 9_000_000;
    localparam int unsigned LEAD_SPACE_NS = 4_500_000;
    localparam int unsigned ONE_SPACE_NS = 1_687_500;
    localparam int unsigned CARRIER_PERIOD_NS = 26_300;

    // ********************************************************************
    // Derived cycle counts
    // ********************************************************************
    localparam int unsigned BURST_CYC = BURST_NS / CLK_PERIOD_NS;
    localparam int unsigned LEAD_MARK_CYC = LEAD_MARK_NS / CLK_PERIOD_NS;
    localparam int unsigned LEAD_SPACE_CYC = LEAD_SPACE_NS / CLK_PERIOD_NS;
    localparam int unsigned ONE_SPACE_CYC = ONE_SPACE_NS / CLK_PERIOD_NS;
    localparam int unsigned CARRIER_HALF_CYC = CARRIER_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ********************************************************************
    // Frame layout and receive tolerance
    // ********************************************************************
    localparam logic [4:0] FIRST_BIT_IDX = 5'h00;
    localparam logic [4:0] LAST_BIT_IDX = 5'h1F;
    localparam int unsigned TOL_SHIFT = 2;
    localparam logic [31:0] RUN_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [15:0] ZERO_HALF = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ********************************************************************
    // State types
    // ********************************************************************
    typedef enum logic [6:0] {
        TX_IDLE = 7'h01,
        TX_LEAD_MARK = 7'h02,
        TX_LEAD_SPACE = 7'h04,
        TX_BIT_MARK = 7'h08,
        TX_BIT_SPACE = 7'h10,
        TX_END_MARK = 7'h20,
        TX_GAP = 7'h40
    } tx_state_t;

    typedef enum logic [2:0] {
        idle_state = 3'h1,
        lead_seen_state = 3'h2,
        bit_collect_state = 3'h4
    } rx_state_t;

endpackage

// ### ir_pulse_distance_txrx.sv
// Pulse-distance infrared transmitter driving an emitter LED, and receiver decoding
// the inverted output of a demodulating receiver module.
// Assumes all inputs are synchronous to CORE_CLK_IN and the receiver idles high.
`timescale 1ns/1ns

// Summary of operation
// RQ1: Transmitter takes an 8-bit address and 8-bit command and frames them.
// RQ2: All protocol timing counts derive from the single core clock.
// RQ3: Bursts last 562.5 us, modulated by a 38 kHz carrier.
// RQ4: Zero is a burst plus equal space, 1.125 ms total.
// RQ5: One is a burst plus 1.6875 ms space, 2.25 ms total.
// RQ6: Frames start with 9 ms burst then 4.5 ms space.
// RQ7: Each data byte is followed by its bitwise inverse.
// RQ8: A final standard burst ends every message.
// RQ9: Frame duration is constant whatever address and command are sent.
// RQ10: Receiver input is inverted: bursts arrive low, spaces high.
// RQ11: Detector finds lead burst; state machine moves idle to lead seen.
// RQ12: Valid lead space moves state from lead seen to bit collecting.
// RQ13: Decoded bits shift into a register, frame shown on outputs.
// RQ14: Outputs give 16-bit custom code, key code and inverted key code.
// RQ15: Frames repeat back to back while enable held; stop on release.
// RQ16: 32-bit body LSB first: address, ~address, command, ~command.
// RQ17: Receiver idles after 32 bits or bad timing; valid only when complete.
module ir_pulse_distance_txrx
    import ir_pd_pkg::*;
#(
    parameter int unsigned BURST_CYCLES = BURST_CYC,
    parameter int unsigned LEAD_MARK_CYCLES = LEAD_MARK_CYC,
    parameter int unsigned LEAD_SPACE_CYCLES = LEAD_SPACE_CYC,
    parameter int unsigned ONE_SPACE_CYCLES = ONE_SPACE_CYC
)
(
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    // Transmit user side
    input wire logic TX_ENABLE_IN,
    input wire logic [7:0] TX_ADDRESS_IN,
    input wire logic [7:0] TX_COMMAND_IN,
    output logic TX_BUSY_OUT,
    // Emitter LED
    output logic IR_LED_OUT,
    // Receiver module
    input wire logic IR_RX_IN,
    // Receive user side
    output logic [15:0] RX_CUSTOM_OUT,
    output logic [7:0] RX_KEY_OUT,
    output logic [7:0] RX_KEY_INV_OUT,
    output logic RX_VALID_OUT
);

    // ********************************************************************
    // Transmitter
    // ********************************************************************
    tx_state_t tx_state_q, tx_state_d;
    logic [31:0] tx_cnt_q, tx_cnt_d;
    logic [31:0] tx_frame_q, tx_frame_d;
    logic [4:0] tx_bit_q, tx_bit_d;
    logic [15:0] car_cnt_q, car_cnt_d;
    logic car_q, car_d;
    logic led_q, led_d;
    logic busy_q, busy_d;
    logic [31:0] tx_len;
    tx_state_t tx_next;

    always_comb
    begin
        tx_state_d = tx_state_q;
        tx_cnt_d = tx_cnt_q + 32'h0000_0001; // RQ2
        tx_frame_d = tx_frame_q;
        tx_bit_d = tx_bit_q;
        tx_len = 32'(BURST_CYCLES); // RQ3
        tx_next = TX_IDLE;
        car_cnt_d = car_cnt_q + 16'h0001;
        car_d = car_q;
        // Free-running carrier; a burst may start mid-cycle, costing at most half a period.
        if (car_cnt_q == 16'(CARRIER_HALF_CYC - 1)) // RQ3
        begin
            car_cnt_d = ZERO_HALF;
            car_d = ~car_q;
        end
        case (tx_state_q)
            TX_IDLE:
            begin
                tx_cnt_d = ZERO_WORD;
                if (TX_ENABLE_IN) // RQ15
                begin
                    tx_frame_d = {~TX_COMMAND_IN, TX_COMMAND_IN, ~TX_ADDRESS_IN,
                        TX_ADDRESS_IN}; // RQ1 RQ7 RQ9 RQ16
                    tx_bit_d = FIRST_BIT_IDX;
                    tx_state_d = TX_LEAD_MARK;
                end
            end
            TX_LEAD_MARK:
            begin
                tx_len = 32'(LEAD_MARK_CYCLES); // RQ6
                tx_next = TX_LEAD_SPACE;
            end
            TX_LEAD_SPACE:
            begin
                tx_len = 32'(LEAD_SPACE_CYCLES); // RQ6
                tx_next = TX_BIT_MARK;
            end
            TX_BIT_MARK:
                tx_next = TX_BIT_SPACE; // RQ3
            TX_BIT_SPACE:
            begin
                tx_len = tx_frame_q[tx_bit_q] ? 32'(ONE_SPACE_CYCLES) : // RQ5
                    32'(BURST_CYCLES); // RQ4
                tx_next = (tx_bit_q == LAST_BIT_IDX) ? TX_END_MARK : TX_BIT_MARK; // RQ16
            end
            TX_END_MARK:
                tx_next = TX_GAP; // RQ8
            // A short dark gap separates repeated frames so a receiver sees the end burst close.
            TX_GAP:
                tx_next = TX_IDLE; // RQ15
            default:
                tx_state_d = TX_IDLE;
        endcase
        // Every timed phase ends alike, so one compare serves them all.
        if (tx_state_q != TX_IDLE && tx_cnt_q == tx_len - 32'h0000_0001)
        begin
            tx_cnt_d = ZERO_WORD;
            tx_state_d = tx_next;
            tx_bit_d = (tx_state_q == TX_BIT_SPACE) ? tx_bit_q + 5'h01 : tx_bit_q;
        end
        led_d = car_q && (tx_state_q == TX_LEAD_MARK || tx_state_q == TX_BIT_MARK ||
            tx_state_q == TX_END_MARK); // RQ3
        busy_d = (tx_state_d != TX_IDLE);
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            tx_state_q <= TX_IDLE;
            tx_cnt_q <= ZERO_WORD;
            tx_frame_q <= ZERO_WORD;
            tx_bit_q <= FIRST_BIT_IDX;
            car_cnt_q <= ZERO_HALF;
            car_q <= 1'b0;
            led_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            tx_state_q <= tx_state_d;
            tx_cnt_q <= tx_cnt_d;
            tx_frame_q <= tx_frame_d;
            tx_bit_q <= tx_bit_d;
            car_cnt_q <= car_cnt_d;
            car_q <= car_d;
            led_q <= led_d;
            busy_q <= busy_d;
        end
    end

    assign IR_LED_OUT = led_q;
    assign TX_BUSY_OUT = busy_q;

    // ********************************************************************
    // Receiver
    // ********************************************************************
    rx_state_t rx_state_q, rx_state_d;
    logic rx_lvl_q, rx_lvl_d;
    logic [31:0] rx_run_q, rx_run_d;
    logic [31:0] rx_shift_q, rx_shift_d;
    logic [4:0] rx_bit_q, rx_bit_d;
    logic [31:0] rx_word_q, rx_word_d;
    logic valid_q, valid_d;
    logic rx_rise, rx_fall, lead_mark_ok, burst_ok, one_ok;

    // Accepts a run within a quarter of its nominal length either way.
    function automatic logic in_window(input logic [31:0] run, input int unsigned nom);
        logic [31:0] n;
        n = 32'(nom);
        return (run >= n - (n >> TOL_SHIFT)) && (run <= n + (n >> TOL_SHIFT));
    endfunction

    always_comb
    begin
        rx_fall = (IR_RX_IN != rx_lvl_q) && !IR_RX_IN; // RQ10
        rx_rise = (IR_RX_IN != rx_lvl_q) && IR_RX_IN; // RQ10
        lead_mark_ok = in_window(rx_run_q, LEAD_MARK_CYCLES);
        burst_ok = in_window(rx_run_q, BURST_CYCLES);
        one_ok = in_window(rx_run_q, ONE_SPACE_CYCLES);
        rx_state_d = rx_state_q;
        rx_lvl_d = IR_RX_IN;
        rx_shift_d = rx_shift_q;
        rx_bit_d = rx_bit_q;
        rx_word_d = rx_word_q;
        valid_d = 1'b0;
        rx_run_d = (rx_run_q == RUN_MAX) ? RUN_MAX : rx_run_q + 32'h0000_0001;
        if (rx_rise || rx_fall)
            rx_run_d = ZERO_WORD;
        case (rx_state_q)
            idle_state:
                if (rx_rise && lead_mark_ok) // RQ11
                    rx_state_d = lead_seen_state;
            lead_seen_state:
                if (rx_fall)
                begin
                    rx_bit_d = FIRST_BIT_IDX;
                    rx_state_d = in_window(rx_run_q, LEAD_SPACE_CYCLES) ?
                        bit_collect_state : idle_state; // RQ12 RQ17
                end
            bit_collect_state:
                if ((rx_rise && !burst_ok) || (rx_fall && !burst_ok && !one_ok)) // RQ17
                    rx_state_d = idle_state;
                else if (rx_fall)
                begin
                    rx_shift_d = {one_ok, rx_shift_q[31:1]}; // RQ13 RQ16
                    rx_bit_d = rx_bit_q + 5'h01;
                    if (rx_bit_q == LAST_BIT_IDX) // RQ17
                    begin
                        rx_word_d = rx_shift_d; // RQ14
                        valid_d = 1'b1;
                        rx_state_d = idle_state;
                    end
                end
            default:
                rx_state_d = idle_state;
        endcase
        // A stuck line never strands the machine mid-frame.
        if (rx_state_q != idle_state &&
            rx_run_q > 32'(LEAD_MARK_CYCLES) + 32'(LEAD_MARK_CYCLES >> TOL_SHIFT)) // RQ17
            rx_state_d = idle_state;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            rx_state_q <= idle_state;
            rx_lvl_q <= 1'b1;
            rx_run_q <= ZERO_WORD;
            rx_shift_q <= ZERO_WORD;
            rx_bit_q <= FIRST_BIT_IDX;
            rx_word_q <= ZERO_WORD;
            valid_q <= 1'b0;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            rx_lvl_q <= rx_lvl_d;
            rx_run_q <= rx_run_d;
            rx_shift_q <= rx_shift_d;
            rx_bit_q <= rx_bit_d;
            rx_word_q <= rx_word_d;
            valid_q <= valid_d;
        end
    end

    assign RX_CUSTOM_OUT = rx_word_q[15:0]; // RQ14
    assign RX_KEY_OUT = rx_word_q[23:16]; // RQ14
    assign RX_KEY_INV_OUT = rx_word_q[31:24]; // RQ14
    assign RX_VALID_OUT = valid_q;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    a_led_dark_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ3
        (tx_state_q == TX_IDLE || tx_state_q == TX_BIT_SPACE) |=> !IR_LED_OUT)
        else $error("LED lit outside a burst");
    a_lead_mark_len: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ6
        (tx_state_q == TX_LEAD_MARK && tx_cnt_q == 32'(LEAD_MARK_CYCLES - 1))
        |=> tx_state_q == TX_LEAD_SPACE && tx_cnt_q == ZERO_WORD)
        else $error("Lead burst length wrong");
    a_zero_space_len: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ4
        (tx_state_q == TX_BIT_SPACE && !tx_frame_q[tx_bit_q] &&
        tx_cnt_q == 32'(BURST_CYCLES - 1)) |=> tx_state_q != TX_BIT_SPACE)
        else $error("Zero space did not end on time");
    a_one_space_len: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ5
        (tx_state_q == TX_BIT_SPACE && tx_frame_q[tx_bit_q] &&
        tx_cnt_q == 32'(BURST_CYCLES - 1)) |=> tx_state_q == TX_BIT_SPACE)
        else $error("One space ended too early");
    a_frame_pairs: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ7
        (tx_state_q != TX_IDLE) |-> (tx_frame_q[15:8] == ~tx_frame_q[7:0] &&
        tx_frame_q[31:24] == ~tx_frame_q[23:16]))
        else $error("Data byte not paired with inverse");
    a_end_after_32: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ8
        $rose(tx_state_q == TX_END_MARK) |-> $past(tx_bit_q) == LAST_BIT_IDX)
        else $error("End burst not after 32 bits");
    a_rx_lead_enter: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ11
        (rx_state_q == idle_state ##1 rx_state_q == lead_seen_state)
        |-> $past(lead_mark_ok) && $past(IR_RX_IN) && !$past(rx_lvl_q))
        else $error("Lead state entered without lead burst");
    a_rx_valid_done: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ17
        RX_VALID_OUT |-> $past(rx_state_q) == bit_collect_state &&
        $past(rx_bit_q) == LAST_BIT_IDX && rx_state_q == idle_state)
        else $error("Valid without complete frame");
    a_rx_fields: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN) // RQ14
        RX_VALID_OUT |-> {RX_KEY_INV_OUT, RX_KEY_OUT, RX_CUSTOM_OUT} == rx_shift_q)
        else $error("Output fields differ from shifted frame");

endmodule // ir_pulse_distance_txrx

// ### ir_remote_model.sv
// Behavioural remote control as seen through a demodulating receiver module.
// Assumes the caller is at a falling clock edge when it asks for a frame.
`timescale 1ns/1ns

module ir_remote_model
#(
    parameter int unsigned BURST = 40,
    parameter int unsigned LEAD_MARK = 640,
    parameter int unsigned LEAD_SPACE = 320,
    parameter int unsigned ONE_SPACE = 120
)
(
    // Clock
    input wire logic clk_in,
    // Demodulated line
    output logic rx_line_out
);
    // ********************************************************************
    // Frame generation
    // ********************************************************************
    // The module output has a pull-up, so high is both space and idle.
    initial rx_line_out = 1'b1;

    task automatic run(input logic level, input int unsigned cycles);
        rx_line_out = level;
        repeat (cycles) @(negedge clk_in);
    endtask

    // Mode 0 is prompt, 1 stretches every run but the closing idle by one eighth (inside tolerance),
    // 2 sends a lead burst of half length, 3 stretches the space of bit 10.
    task automatic send(input logic [7:0] a, input logic [7:0] c, input int unsigned mode);
        logic [31:0] w;
        int unsigned k;
        w = {~c, c, ~a, a};
        k = (mode == 1) ? 9 : 8;
        run(1'b0, ((mode == 2) ? LEAD_MARK / 2 : LEAD_MARK) * k / 8);
        run(1'b1, LEAD_SPACE * k / 8);
        for (int i = 0; i < 32; i++)
        begin
            run(1'b0, BURST * k / 8);
            run(1'b1, ((mode == 3 && i == 10) ? 3 * ONE_SPACE : (w[i] ? ONE_SPACE : BURST)) * k / 8);
        end
        run(1'b0, BURST * k / 8);
        run(1'b1, 4 * BURST);
    endtask
endmodule // ir_remote_model

// ### tb.sv
// Self-checking bench for the infrared transmitter and receiver pair.
// Assumes shortened protocol counts; the carrier is then slower than a burst, so
// frame timing is judged on the busy flag and the emitter only for lighting at all and staying dark outside frames.
`timescale 1ns/1ns

module tb;
    import ir_pd_pkg::*;
    // ********************************************************************
    // Setup
    // ********************************************************************
    localparam int unsigned B = 40;
    localparam int unsigned LM = 640;
    localparam int unsigned LS = 320;
    localparam int unsigned OS = 120;
    localparam int unsigned FRAME_T = LM + LS + 16 * 2 * B + 16 * (B + OS) + 2 * B;
    // Each of the 68 phases may spend one extra edge on its state change.
    localparam int unsigned SLACK = 70;
    localparam int unsigned CEIL = 60000;

    logic clk, rst_b, tx_en, busy, led, rx_line, rx_valid, prev_busy, prev_valid;
    logic led_bad, long_valid;
    logic [7:0] tx_addr, tx_cmd, rx_key, rx_key_inv;
    logic [15:0] rx_custom;
    logic [31:0] cap, hi_len, lo_len, run_len;
    int unsigned n_valid, bad_count, n_checks, cyc, led_on;

    ir_pulse_distance_txrx #(.BURST_CYCLES(B), .LEAD_MARK_CYCLES(LM),
        .LEAD_SPACE_CYCLES(LS), .ONE_SPACE_CYCLES(OS)) dut (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .TX_ENABLE_IN(tx_en),
        .TX_ADDRESS_IN(tx_addr), .TX_COMMAND_IN(tx_cmd), .TX_BUSY_OUT(busy),
        .IR_LED_OUT(led), .IR_RX_IN(rx_line), .RX_CUSTOM_OUT(rx_custom),
        .RX_KEY_OUT(rx_key), .RX_KEY_INV_OUT(rx_key_inv), .RX_VALID_OUT(rx_valid));

    ir_remote_model #(.BURST(B), .LEAD_MARK(LM), .LEAD_SPACE(LS), .ONE_SPACE(OS)) remote (
        .clk_in(clk), .rx_line_out(rx_line));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ********************************************************************
    // Monitors
    // ********************************************************************
    initial
    begin
        {prev_busy, prev_valid, led_bad, long_valid} = 4'h0;
        {hi_len, lo_len, run_len} = '0;
        {n_valid, cyc, bad_count, n_checks, led_on} = '0;
        cap = 32'h0000_0000;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == CEIL)
        begin
            bad_count++;
            final_report();
        end
        if (busy !== prev_busy)
        begin
            if (prev_busy === 1'b1) hi_len <= run_len;
            else lo_len <= run_len;
            run_len <= 32'h0000_0001;
        end
        else run_len <= run_len + 1;
        if (rst_b === 1'b1 && prev_busy === 1'b0 && busy === 1'b0 && led !== 1'b0) led_bad <= 1'b1;
        if (led === 1'b1) led_on <= led_on + 1;
        if (rx_valid === 1'b1)
        begin
            n_valid <= n_valid + 1;
            cap <= {rx_key_inv, rx_key, rx_custom};
        end
        if (rx_valid === 1'b1 && prev_valid === 1'b1) long_valid <= 1'b1;
        prev_busy <= busy;
        prev_valid <= rx_valid;
    end

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic chk_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input logic [31:0] lo, input logic [31:0] hi,
        input logic [31:0] got);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            bad_count++;
            $display("FAIL %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wait_busy(input logic v);
        int unsigned k;
        k = 0;
        while (busy !== v && k < 6000)
        begin
            @(negedge clk);
            k++;
        end
        chk_eq("busy level", {31'h0, v}, {31'h0, busy});
    endtask

    task automatic rx_frame(input logic [7:0] a, input logic [7:0] c, input int unsigned mode);
        int unsigned n0;
        n0 = n_valid;
        remote.send(a, c, mode);
        repeat (10) @(negedge clk);
        if (mode < 2)
        begin
            chk_eq("frame count", n0 + 1, n_valid);
            chk_eq("received word", {~c, c, ~a, a}, cap);
        end
        else
            chk_eq("aborted frame count", n0, n_valid);
    endtask

    task automatic rx_test();
        logic [7:0] ca [4];
        ca = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
        for (int i = 0; i < 4; i++) rx_frame(ca[i], ~ca[i], i);
        for (int i = 0; i < 3; i++) rx_frame(8'($urandom), 8'($urandom), $urandom % 2);
    endtask

    task automatic tx_test();
        logic [31:0] first_len;
        tx_addr = 8'($urandom);
        tx_cmd = 8'($urandom);
        tx_en = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        // New data must be in place before the next start edge; the run monitor
        // records a finished run one edge after busy changes, so look one cycle later.
        tx_addr = ~tx_addr;
        tx_cmd = 8'($urandom);
        @(negedge clk);
        first_len = hi_len;
        chk_rng("frame length", FRAME_T, FRAME_T + SLACK, first_len);
        @(negedge clk);
        chk_rng("gap between frames", 1, 2, lo_len);
        wait_busy(1'b1);
        wait_busy(1'b0);
        @(negedge clk);
        chk_eq("second frame length", first_len, hi_len);
        wait_busy(1'b1);
        tx_en = 1'b0;
        wait_busy(1'b0);
        @(negedge clk);
        chk_eq("released frame length", first_len, hi_len);
        repeat (300) @(negedge clk);
        chk_eq("busy after release", 32'h0000_0000, {31'h0, busy});
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial
    begin
        rst_b = 1'b0;
        tx_en = 1'b0;
        tx_addr = 8'h00;
        tx_cmd = 8'h00;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk_eq("outputs after reset", 32'h0000_0000,
            {rx_custom, rx_key, rx_valid, busy, led, 5'h00});
        void'($urandom(7524));
        fork
            tx_test();
            rx_test();
        join
        chk_eq("valid pulse width", 32'h0000_0000, {31'h0, long_valid});
        chk_eq("emitter dark outside frames", 32'h0000_0000, {31'h0, led_bad});
        chk_rng("emitter lit cycles", 1, 3 * FRAME_T, led_on);
        final_report();
    end
endmodule // tb
